// >>> rtl/shrp_map.svh
// Constants of the serial host register port: address map, fields and timing
`ifndef SHRP_MAP_SVH
`define SHRP_MAP_SVH
// ****************************************************************
// Clock and bus rates
// ****************************************************************
`define SHRP_CLK_HZ 10000000
`define SHRP_I2C_SM_BPS 100000
`define SHRP_I2C_FM_BPS 400000
`define SHRP_SPI_MAX_HZ 33000000
// ****************************************************************
// Slave address built from the two straps
// ****************************************************************
`define SHRP_ADDR_BASE 8'h90
`define SHRP_ADDR_HI_STEP 8'h08
`define SHRP_ADDR_LO_STEP 8'h02
// ****************************************************************
// Sub-address and first-byte fields
// ****************************************************************
`define SHRP_RW_BIT 7
`define SHRP_IDX_MSB 6
`define SHRP_IDX_LSB 3
`define SHRP_CH_MSB 2
`define SHRP_CH_LSB 1
`define SHRP_FIFO_IDX 4'h0
`define SHRP_BURST_MAX 7'h40
`define SHRP_RDATA_RST 8'h00
`endif

// >>> rtl/shrp_pkg.sv
// Types shared by the serial host register port
package shrp_pkg;
    // One register access handed to the UART core
    typedef struct packed {
        logic wr;
        logic chan;
        logic [3:0] idx;
        logic [7:0] data;
    } shrp_req_s;

    // Two-wire slave states, one-hot
    typedef enum logic [8:0] {
        I2C_IDLE = 9'h001,
        I2C_ADDR = 9'h002,
        I2C_ADDR_ACK = 9'h004,
        I2C_SUB = 9'h008,
        I2C_SUB_ACK = 9'h010,
        I2C_WDATA = 9'h020,
        I2C_WACK = 9'h040,
        I2C_RDATA = 9'h080,
        I2C_RACK = 9'h100
    } shrp_i2c_e;
endpackage

// >>> rtl/shrp_buf.sv
// Two-entry request buffer with valid and ready on both sides
`timescale 1ns/1ps
module shrp_buf #(
    parameter int WIDTH = 14
) (
    input wire logic clk,                 // System clock
    input wire logic rst,                 // Synchronous reset, active high
    input wire logic in_valid,            // Producer offers a word
    output logic in_ready,                // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word offered
    output logic out_valid,               // Head word present
    input wire logic out_ready,           // Consumer takes the head
    output logic [WIDTH-1:0] out_data     // Head word, from a flop
);
    logic [WIDTH-1:0] head_q;
    logic [WIDTH-1:0] tail_q;
    logic head_v_q;
    logic tail_v_q;
    logic push;
    logic pop;

    // Ready only from the tail flop, so a stalled consumer never loses a word
    assign in_ready = ~tail_v_q;
    assign out_valid = head_v_q;
    assign out_data = head_q;
    assign push = in_valid & in_ready;
    assign pop = head_v_q & out_ready;

    // Head fills first, tail second; the tail refills the head on a pop
    always_ff @(posedge clk) begin
        if (rst) begin
            head_v_q <= 1'b0;
            tail_v_q <= 1'b0;
        end else if (pop) begin
            if (tail_v_q) begin
                head_q <= tail_q;
                tail_v_q <= push;
                if (push) begin
                    tail_q <= in_data;
                end
            end else begin
                head_v_q <= push;
                head_q <= in_data;
            end
        end else if (push) begin
            if (!head_v_q) begin
                head_q <= in_data;
                head_v_q <= 1'b1;
            end else begin
                tail_q <= in_data;
                tail_v_q <= 1'b1;
            end
        end
    end

    // A full buffer holds its head until the consumer takes it
    a_buf_hold_head: assert property (@(posedge clk) disable iff (rst)
        (head_v_q && !out_ready) |=> (head_v_q && head_q == $past(head_q)))
        else $error("Buffer head changed while stalled");
endmodule

// >>> rtl/shrp_top.sv
// Serial host register port: two-wire or four-wire slave reaching UART registers
// Function
// - Two-wire slave works at Standard 100 kbps and Fast 400 kbps rates.
// - Address byte bit 0 high means read, low means write.
// - Each written byte is acknowledged by pulling data low one clock, except a byte to a reserved channel, into a full buffer or into a full transmit FIFO.
// - Write to a full transmit FIFO gets a negative acknowledge.
// - Slave address is base from high strap plus offset from low strap.
// - Sub-address bits 6:3 are register index, bits 2:1 channel.
// - Channel code 00 is first UART, 01 second, others reserved.
// - Four-line serial port with select, clock, input and output.
// - First byte: bit 7 direction, 6:3 index, 2:1 channel.
// - One select period carries up to 64 FIFO bytes either way.
// - Write to index zero without divisor access pushes the transmit FIFO.
// - Read of index zero without divisor access pops the receive FIFO.
`timescale 1ns/1ps
`include "shrp_map.svh"
module shrp_top (
    input wire logic clk,                  // System clock, 10 MHz
    input wire logic rst,                  // Synchronous reset, active high
    input wire logic spi_sel,              // Bus strap: high selects four-wire port
    input wire logic [1:0] addr_strap_high, // High strap: 0 supply,1 ground,2 clock,3 data
    input wire logic [1:0] addr_strap_low, // Low strap, same coding
    input wire logic i2c_scl_in,           // Two-wire clock level
    input wire logic i2c_sda_in,           // Two-wire data level
    output logic i2c_sda_out,              // Data drive value, always low
    output logic i2c_sda_oe,               // Pulls data low while high
    input wire logic spi_sclk,             // Four-wire serial clock
    input wire logic spi_cs_n,             // Four-wire select, active low
    input wire logic spi_si,               // Slave input
    output logic spi_so_out,               // Slave output value
    output logic spi_so_oe,                // Slave output enable
    output logic req_valid,                // Register access pending
    input wire logic req_ready,            // Core takes the access
    output shrp_pkg::shrp_req_s req,       // Access: direction, channel, index, data
    input wire logic rd_valid,             // Core returns read data
    input wire logic [7:0] rd_data,        // Read data
    input wire logic [1:0] tx_full,        // Transmit FIFO full, per channel
    input wire logic [1:0] lcr_dlab        // Divisor-access bit of line_control_reg
);
    // ****************************************************************
    // Pin synchronisers and edge detection
    // ****************************************************************
    logic [9:0] pin_s1_q;
    logic [9:0] pin_s2_q;
    logic [3:0] edge_q;
    logic scl_h, sda_h, sclk_h, cs_n_h, si_h;
    logic scl_rise, scl_fall, i2c_start, i2c_stop, sclk_rise, sclk_fall;

    // Two flops before use; 25 samples per Fast-mode bit is ample
    always_ff @(posedge clk) begin
        pin_s1_q <= {spi_sel, addr_strap_high, addr_strap_low, i2c_scl_in, i2c_sda_in,
                     spi_sclk, spi_cs_n, spi_si};
        pin_s2_q <= pin_s1_q;
        edge_q <= pin_s2_q[4:1];
    end

    assign scl_h = pin_s2_q[4];
    assign sda_h = pin_s2_q[3];
    assign sclk_h = pin_s2_q[2];
    assign cs_n_h = pin_s2_q[1];
    assign si_h = pin_s2_q[0];
    assign scl_rise = scl_h & ~edge_q[3];
    assign scl_fall = ~scl_h & edge_q[3];
    // Start and stop are data edges while the clock stays high
    assign i2c_start = scl_h & edge_q[3] & edge_q[2] & ~sda_h;
    assign i2c_stop = scl_h & edge_q[3] & ~edge_q[2] & sda_h;
    assign sclk_rise = sclk_h & ~edge_q[1];
    assign sclk_fall = ~sclk_h & edge_q[1];

    // ****************************************************************
    // Strap capture after reset
    // ****************************************************************
    logic cap_pend_q;
    logic spi_mode_q;
    logic [7:0] my_addr_q;

    function automatic logic [7:0] shrp_addr(input logic [1:0] hi, input logic [1:0] lo);
        return `SHRP_ADDR_BASE + 8'(hi * `SHRP_ADDR_HI_STEP) + 8'(lo * `SHRP_ADDR_LO_STEP);
    endfunction

    // Straps are sampled once after release, never loaded under reset
    always_ff @(posedge clk) begin
        if (rst) begin
            cap_pend_q <= 1'b1;
            spi_mode_q <= 1'b0;
            my_addr_q <= `SHRP_ADDR_BASE;
        end else if (cap_pend_q) begin
            cap_pend_q <= 1'b0;
            spi_mode_q <= pin_s2_q[9];
            my_addr_q <= shrp_addr(pin_s2_q[8:7], pin_s2_q[6:5]);
        end
    end

    // ****************************************************************
    // Shared decoding and read data
    // ****************************************************************
    logic [7:0] rdata_q;

    // Only codes 00 and 01 reach a channel
    function automatic logic shrp_ch_ok(input logic [1:0] ch);
        return ~ch[1];
    endfunction

    // Transmit FIFO port full with divisor access off: byte would be lost
    function automatic logic shrp_refuse(input logic [3:0] idx, input logic [1:0] ch,
                                         input logic [1:0] full, input logic [1:0] dlab);
        return (idx == `SHRP_FIFO_IDX) && full[ch[0]] && !dlab[ch[0]];
    endfunction

    // Last byte returned by the core feeds both serial engines
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= `SHRP_RDATA_RST;
        end else if (rd_valid) begin
            rdata_q <= rd_data;
        end
    end

    // ****************************************************************
    // Two-wire slave engine
    // ****************************************************************
    shrp_pkg::shrp_i2c_e ist_q;
    logic [3:0] ibit_q;
    logic [7:0] ish_q;
    logic idir_q, inack_q, ireq_v_q, buf_in_ready;
    logic [1:0] ich_q;
    logic [3:0] iidx_q;
    shrp_pkg::shrp_req_s ireq_q;

    // Bits are taken on clock rise and changed on clock fall
    always_ff @(posedge clk) begin
        ireq_v_q <= 1'b0;
        i2c_sda_out <= 1'b0;
        if (rst || spi_mode_q) begin
            ist_q <= shrp_pkg::I2C_IDLE;
            ibit_q <= 4'h0;
            idir_q <= 1'b0;
            inack_q <= 1'b0;
            ich_q <= 2'h0;
            iidx_q <= 4'h0;
            i2c_sda_oe <= 1'b0;
        end else if (i2c_start) begin
            ist_q <= shrp_pkg::I2C_ADDR; // Repeated start keeps the sub-address
            ibit_q <= 4'h0;
            i2c_sda_oe <= 1'b0;
        end else if (i2c_stop) begin
            ist_q <= shrp_pkg::I2C_IDLE;
            i2c_sda_oe <= 1'b0;
        end else if (scl_rise) begin
            case (ist_q)
                shrp_pkg::I2C_ADDR, shrp_pkg::I2C_SUB, shrp_pkg::I2C_WDATA: begin
                    ish_q <= {ish_q[6:0], sda_h};
                    ibit_q <= ibit_q + 4'h1;
                end
                shrp_pkg::I2C_RACK: begin
                    if (sda_h) begin
                        ist_q <= shrp_pkg::I2C_IDLE; // Master refused: read ends
                    end else if (shrp_ch_ok(ich_q)) begin
                        ireq_v_q <= 1'b1; // Fetch next byte, pops at index 0
                        ireq_q <= '{wr: 1'b0, chan: ich_q[0], idx: iidx_q, data: 8'h00};
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (ist_q)
                shrp_pkg::I2C_ADDR: begin
                    if (ibit_q == 4'h8) begin
                        ibit_q <= 4'h0;
                        if (ish_q[7:1] == my_addr_q[7:1]) begin
                            ist_q <= shrp_pkg::I2C_ADDR_ACK;
                            i2c_sda_oe <= 1'b1;
                            idir_q <= ish_q[0];
                            if (ish_q[0] && shrp_ch_ok(ich_q)) begin
                                ireq_v_q <= 1'b1;
                                ireq_q <= '{wr: 1'b0, chan: ich_q[0], idx: iidx_q,
                                            data: 8'h00};
                            end
                        end else begin
                            ist_q <= shrp_pkg::I2C_IDLE;
                        end
                    end
                end
                shrp_pkg::I2C_SUB: begin
                    if (ibit_q == 4'h8) begin
                        ibit_q <= 4'h0;
                        iidx_q <= ish_q[`SHRP_IDX_MSB:`SHRP_IDX_LSB];
                        ich_q <= ish_q[`SHRP_CH_MSB:`SHRP_CH_LSB];
                        ist_q <= shrp_pkg::I2C_SUB_ACK;
                        i2c_sda_oe <= 1'b1;
                    end
                end
                shrp_pkg::I2C_WDATA: begin
                    if (ibit_q == 4'h8) begin
                        ibit_q <= 4'h0;
                        ist_q <= shrp_pkg::I2C_WACK;
                        // Full FIFO, reserved channel or full buffer: leave data high
                        if (shrp_ch_ok(ich_q) && buf_in_ready &&
                            !shrp_refuse(iidx_q, ich_q, tx_full, lcr_dlab)) begin
                            i2c_sda_oe <= 1'b1;
                            inack_q <= 1'b0;
                            ireq_v_q <= 1'b1;
                            ireq_q <= '{wr: 1'b1, chan: ich_q[0], idx: iidx_q, data: ish_q};
                        end else begin
                            inack_q <= 1'b1;
                        end
                    end
                end
                shrp_pkg::I2C_ADDR_ACK: begin
                    if (idir_q) begin
                        ist_q <= shrp_pkg::I2C_RDATA;
                        ibit_q <= 4'h1;
                        i2c_sda_oe <= ~rdata_q[7];
                    end else begin
                        ist_q <= shrp_pkg::I2C_SUB;
                        i2c_sda_oe <= 1'b0;
                    end
                end
                shrp_pkg::I2C_SUB_ACK: begin
                    ist_q <= shrp_pkg::I2C_WDATA;
                    i2c_sda_oe <= 1'b0;
                end
                shrp_pkg::I2C_WACK: begin
                    ist_q <= inack_q ? shrp_pkg::I2C_IDLE : shrp_pkg::I2C_WDATA;
                    i2c_sda_oe <= 1'b0;
                end
                shrp_pkg::I2C_RDATA: begin
                    if (ibit_q == 4'h8) begin
                        ist_q <= shrp_pkg::I2C_RACK;
                        i2c_sda_oe <= 1'b0;
                    end else begin
                        i2c_sda_oe <= ~rdata_q[3'(4'h7 - ibit_q)];
                        ibit_q <= ibit_q + 4'h1;
                    end
                end
                shrp_pkg::I2C_RACK: begin
                    ist_q <= shrp_pkg::I2C_RDATA;
                    ibit_q <= 4'h1;
                    i2c_sda_oe <= ~rdata_q[7];
                end
                default: begin
                end
            endcase
        end
    end

    // ****************************************************************
    // Four-wire slave engine, clock idles low, mode 0
    // ****************************************************************
    logic [2:0] sbit_q;
    logic [7:0] ssh_q;
    logic [7:0] spi_byte;
    logic sfirst_q, sdir_q, sreq_v_q;
    logic [1:0] sch_q;
    logic [3:0] sidx_q;
    logic [6:0] scnt_q;
    shrp_pkg::shrp_req_s sreq_q;

    assign spi_byte = {ssh_q[6:0], si_h};

    // Select high clears the byte framing and releases the output
    always_ff @(posedge clk) begin
        sreq_v_q <= 1'b0;
        if (rst || !spi_mode_q || cs_n_h) begin
            sbit_q <= 3'h0;
            sfirst_q <= 1'b1;
            sdir_q <= 1'b0;
            scnt_q <= 7'h00;
            sch_q <= 2'h0;
            sidx_q <= 4'h0;
            spi_so_out <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            spi_so_oe <= 1'b1;
            if (sclk_rise) begin
                ssh_q <= spi_byte; // Input taken on rising edge
                sbit_q <= sbit_q + 3'h1;
                if (sbit_q == 3'h7 && sfirst_q) begin
                    sfirst_q <= 1'b0;
                    sdir_q <= spi_byte[`SHRP_RW_BIT];
                    sidx_q <= spi_byte[`SHRP_IDX_MSB:`SHRP_IDX_LSB];
                    sch_q <= spi_byte[`SHRP_CH_MSB:`SHRP_CH_LSB];
                    if (spi_byte[`SHRP_RW_BIT] && shrp_ch_ok(spi_byte[2:1])) begin
                        sreq_v_q <= 1'b1;
                        scnt_q <= 7'h01;
                        sreq_q <= '{wr: 1'b0, chan: spi_byte[1],
                                    idx: spi_byte[`SHRP_IDX_MSB:`SHRP_IDX_LSB], data: 8'h00};
                    end
                end else if (sbit_q == 3'h7 && scnt_q < `SHRP_BURST_MAX && shrp_ch_ok(sch_q)) begin
                    scnt_q <= scnt_q + 7'h01; // Burst capped at 64 bytes
                    if (sdir_q) begin
                        sreq_v_q <= 1'b1; // Prefetch of the next byte
                        sreq_q <= '{wr: 1'b0, chan: sch_q[0], idx: sidx_q, data: 8'h00};
                    end else if (buf_in_ready &&
                                 !shrp_refuse(sidx_q, sch_q, tx_full, lcr_dlab)) begin
                        sreq_v_q <= 1'b1;
                        sreq_q <= '{wr: 1'b1, chan: sch_q[0], idx: sidx_q, data: spi_byte};
                    end
                end
            end
            if (sclk_fall) begin
                // Output changes on falling edge, MSB first
                spi_so_out <= !sfirst_q && sdir_q && rdata_q[3'(3'h7 - sbit_q)];
            end
        end
    end

    // ****************************************************************
    // Request buffer towards the UART core
    // ****************************************************************
    shrp_buf #(.WIDTH($bits(shrp_pkg::shrp_req_s))) u_buf (
        .clk(clk),
        .rst(rst),
        .in_valid(spi_mode_q ? sreq_v_q : ireq_v_q),
        .in_ready(buf_in_ready),
        .in_data(spi_mode_q ? sreq_q : ireq_q),
        .out_valid(req_valid),
        .out_ready(req_ready),
        .out_data(req)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_sub_ack_low: assert property (ist_q == shrp_pkg::I2C_SUB_ACK |-> i2c_sda_oe)
        else $error("Sub-address not acknowledged");
    a_full_nack: assert property ((ist_q == shrp_pkg::I2C_WDATA && scl_fall && !i2c_stop
        && !i2c_start && ibit_q == 4'h8 && shrp_refuse(iidx_q, ich_q, tx_full, lcr_dlab))
        |=> (!i2c_sda_oe && !ireq_v_q && inack_q) ##1 (!i2c_sda_oe || ist_q != shrp_pkg::I2C_WACK))
        else $error("Full transmit FIFO write was acknowledged");
    a_dir_bit_take: assert property ((ist_q == shrp_pkg::I2C_ADDR && scl_fall
        && ibit_q == 4'h8 && !i2c_start && !i2c_stop && ish_q[7:1] == my_addr_q[7:1])
        |=> (ist_q == shrp_pkg::I2C_ADDR_ACK && idir_q == $past(ish_q[0])))
        else $error("Direction bit misread");
    a_addr_range: assert property (!cap_pend_q |-> (my_addr_q[7:4] inside {4'h9, 4'hA}
        && !my_addr_q[0]))
        else $error("Slave address outside strap range");
    a_i2c_fields: assert property (ireq_v_q && !spi_mode_q |->
        (ireq_q.idx == iidx_q && ireq_q.chan == ich_q[0]))
        else $error("Request fields differ from sub-address");
    a_chan_reserved: assert property (ireq_v_q && !spi_mode_q |-> !ich_q[1])
        else $error("Reserved channel reached the core");
    a_spi_cmd_take: assert property ((spi_mode_q && !cs_n_h && sclk_rise && sfirst_q
        && sbit_q == 3'h7) |=> (!sfirst_q && sdir_q == $past(ssh_q[6])))
        else $error("Command byte direction misread");
    a_burst_cap: assert property (scnt_q <= `SHRP_BURST_MAX)
        else $error("Burst exceeded 64 bytes");
    a_so_release: assert property ((cs_n_h || !spi_mode_q) |=> !spi_so_oe)
        else $error("Slave output driven while deselected");
    a_write_no_full: assert property ((sreq_v_q && sreq_q.wr) |->
        !$past(shrp_refuse(sidx_q, sch_q, tx_full, lcr_dlab)))
        else $error("Byte pushed into a full transmit FIFO");

    c_i2c_write: cover property (ist_q == shrp_pkg::I2C_WACK && i2c_sda_oe);
    c_i2c_nack: cover property (ist_q == shrp_pkg::I2C_WACK && inack_q);
    c_i2c_read: cover property (ist_q == shrp_pkg::I2C_RACK ##[1:300] ireq_v_q);
    c_spi_burst: cover property (scnt_q == `SHRP_BURST_MAX);
endmodule

// >>> dv/shrp_master_model.sv
// Host master model for the two-wire and four-wire ports
`timescale 1ns/1ps
module shrp_master_model (
    input wire logic clk,   // System clock
    input wire logic sda_w, // Resolved data line
    input wire logic so,    // Slave output line
    output logic scl,       // Two-wire clock
    output logic sda,       // Data drive, high releases
    output logic sclk,      // Four-wire clock
    output logic cs_n,      // Select, active low
    output logic si         // Slave input
);
    int q = 7; // Quarter bit: 28 clocks a bit stays under 400 kbps
    // Both buses idle, data released
    initial {scl, sda, sclk, cs_n, si} = 5'h1A;
    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Data falls with clock high, also as repeated start
    task automatic start;
        sda <= 1'b1;
        w(q);
        scl <= 1'b1;
        w(q);
        sda <= 1'b0;
        w(q);
        scl <= 1'b0;
    endtask
    // Data rises with clock high; clock stays high at idle
    task automatic stop;
        w(q);
        sda <= 1'b0;
        w(q);
        scl <= 1'b1;
        w(q);
        sda <= 1'b1;
        w(q);
    endtask
    // Byte and acknowledge slot, MSB first, data moved only while clock low
    task automatic bits(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--) begin
            w(q);
            sda <= tx[i];
            w(q);
            scl <= 1'b1;
            w(q);
            rx[i] = sda_w;
            w(q);
            scl <= 1'b0;
        end
    endtask
    // Select first, mode 0; slow clock since the port oversamples
    task automatic spi(input logic [7:0] tx, output logic [7:0] rx);
        cs_n <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            si <= tx[i];
            w(10);
            sclk <= 1'b1;
            rx[i] = so;
            w(10);
            sclk <= 1'b0;
        end
    endtask
    // Clock already back low when select rises
    task automatic spi_end;
        w(10);
        cs_n <= 1'b1;
    endtask
endmodule

// >>> dv/shrp_top_tb.sv
// Self-checking bench for the serial host register port
`timescale 1ns/1ps
module shrp_top_tb;
    logic clk = 1'b0, rst = 1'b1, spi_sel = 1'b0, stall = 1'b0, ch;
    logic req_ready = 1'b0, rd_valid = 1'b0, sda_oe, sda_out, so_out, so_oe, req_valid;
    logic m_scl, m_sda, sclk, cs_n, si;
    logic [1:0] hi = 2'h0, lo = 2'h0, tx_full = 2'h0, lcr_dlab = 2'h0;
    logic [7:0] rd_data = 8'h00, a, d, wd[64];
    logic [8:0] rx;
    logic [31:0] rs = 32'h8C62;
    logic [3:0] idx;
    shrp_pkg::shrp_req_s req, got_q[$];
    logic [7:0] rd_q[$];
    int n_fail = 0, checked = 0;
    initial forever #50 clk = ~clk;
    shrp_top i_dut (.clk(clk), .rst(rst), .spi_sel(spi_sel), .addr_strap_high(hi),
        .addr_strap_low(lo), .i2c_scl_in(m_scl), .i2c_sda_in(m_sda & ~sda_oe),
        .i2c_sda_out(sda_out), .i2c_sda_oe(sda_oe), .spi_sclk(sclk), .spi_cs_n(cs_n),
        .spi_si(si), .spi_so_out(so_out), .spi_so_oe(so_oe), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .rd_valid(rd_valid), .rd_data(rd_data),
        .tx_full(tx_full), .lcr_dlab(lcr_dlab));
    // Undriven output toggles so a stale bit cannot pass
    shrp_master_model i_m (.clk(clk), .sda_w(m_sda & ~sda_oe), .so(so_oe ? so_out : clk),
        .scl(m_scl), .sda(m_sda), .sclk(sclk), .cs_n(cs_n), .si(si));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    // Core side: random stalls, read data the cycle after each read
    always @(posedge clk) begin
        rs <= lfsr(rs);
        req_ready <= !stall & (rs[0] | rs[3]);
        rd_valid <= 1'b0;
        if (req_valid & req_ready) begin
            got_q.push_back(req);
            rd_valid <= !req.wr;
            rd_data <= rs[15:8];
            if (!req.wr) rd_q.push_back(rs[15:8]);
        end
    end
    task automatic chk(input string nm, input logic [13:0] e, input logic [13:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic end_of_test;
        if (n_fail == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic reset;
        rst <= 1'b1;
        i_m.w(5);
        rst <= 1'b0;
        i_m.w(4);
    endtask
    task automatic wbyte(input logic [7:0] v, input logic e);
        i_m.bits({v, 1'b1}, rx);
        chk("data ack", e, rx[0]);
    endtask
    task automatic hdr(input logic [7:0] sub);
        i_m.start;
        wbyte(a, 1'b0);
        wbyte(sub, 1'b0);
    endtask
    // ********
    // Main sequence: every strap code, then the four-wire port
    // ********
    initial begin
        for (int k = 0; k < 4; k++) begin
            hi <= 2'(k);
            lo <= 2'(3 - k);
            i_m.q = (k == 0) ? 25 : 7; // Standard mode on the first pass
            reset;
            a = 8'h90 + 8'(8 * k + 2 * (3 - k));
            idx = rs[7:4];
            ch = rs[9];
            d = rs[23:16];
            hdr({1'b0, idx, 1'b0, ch, 1'b0});
            wbyte(d, 1'b0);
            i_m.stop;
            i_m.w(20);
            chk("write req", {1'b1, ch, idx, d}, got_q.pop_front());
            i_m.start;
            wbyte(a ^ 8'h08, 1'b1);
            i_m.stop;
            tx_full <= 2'h3;
            hdr({5'h00, ch, 1'b0});
            wbyte(d, 1'b1);
            i_m.stop;
            // Divisor access on: a full transmit FIFO must not refuse index zero
            lcr_dlab <= 2'h3;
            hdr({5'h00, ch, 1'b0});
            wbyte(d, 1'b0);
            i_m.stop;
            tx_full <= 2'h0;
            lcr_dlab <= 2'h0;
            i_m.w(20);
            chk("divisor write", {1'b1, ch, 4'h0, d}, got_q.pop_front());
            hdr({1'b0, idx, 1'b0, ch, 1'b0});
            i_m.start;
            wbyte(a | 8'h01, 1'b0);
            for (int j = 0; j < 2; j++) begin
                i_m.bits({8'hFF, 1'(j)}, rx);
                chk("i2c read", rd_q.pop_front(), rx[8:1]);
            end
            i_m.stop;
            chk("read count", 14'h2, 14'(got_q.size()));
            chk("sda drive", 1'b0, sda_out);
            got_q.delete();
            // Stalled core: third write finds the buffer full
            stall <= 1'b1;
            hdr({1'b0, idx | 4'h1, 1'b0, ch, 1'b0});
            for (int j = 0; j < 3; j++) wbyte(d, 1'(j / 2));
            i_m.stop;
            stall <= 1'b0;
            i_m.w(20);
            chk("held writes", 14'h2, 14'(got_q.size()));
            got_q.delete();
        end
        spi_sel <= 1'b1;
        reset;
        i_m.spi(8'h02, rx[7:0]);
        for (int j = 0; j < 65; j++) begin
            d = rs[7:0];
            if (j < 64) wd[j] = d;
            i_m.spi(d, rx[7:0]);
        end
        i_m.spi_end;
        i_m.w(20);
        chk("burst count", 14'h40, 14'(got_q.size()));
        for (int j = 0; j < 64; j++) begin
            chk("burst", {2'h3, 4'h0, wd[j]}, got_q.pop_front());
        end
        i_m.spi(8'h80, rx[7:0]);
        for (int j = 0; j < 2; j++) begin
            i_m.spi(8'h00, rx[7:0]);
            chk("spi read", rd_q.pop_front(), rx[7:0]);
        end
        i_m.spi_end;
        i_m.w(5);
        chk("so released", 1'b0, so_oe);
        end_of_test;
    end
    // Watchdog well beyond the expected run
    initial begin
        i_m.w(90000);
        n_fail++;
        end_of_test;
    end
endmodule
